// *** src/tap_pkg.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose : shared constants and types of the serial test access port
// Assumes : both ends run on a 20 MHz core_clk
// Notes   : the link clock period is set by the host-side divider
////////////////////////////////////////////////////////////////////////////////
package tap_pkg;
  // clocking of the host divider
  localparam int unsigned CORE_PERIOD_NS = 50;
  localparam int unsigned TCK_PERIOD_NS  = 1000;
  localparam int unsigned TCK_HALF_CYC   = TCK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam logic [4:0]  TCK_HALF_LAST  = 5'(TCK_HALF_CYC - 1);

  // register widths
  localparam int unsigned IR_W  = 4;
  localparam int unsigned DR_W  = 32;
  localparam int unsigned BND_W = 8;
  localparam int unsigned AUX_W = 8;
  localparam int unsigned VEC_W = 40;

  // instruction codes and the fixed capture value
  localparam logic [3:0] IR_CAPTURE       = 4'h1;
  localparam logic [3:0] INSTR_BND_DRIVE  = 4'h0;
  localparam logic [3:0] INSTR_ID         = 4'h1;
  localparam logic [3:0] INSTR_BND_SAMPLE = 4'h2;
  localparam logic [3:0] INSTR_PROG       = 4'h4;
  localparam logic [3:0] INSTR_ISCAN      = 4'h8;
  localparam logic [3:0] INSTR_BREAK      = 4'hA;
  localparam logic [3:0] INSTR_BYPASS     = 4'hF;

  // host mode-select headers, sent first bit first
  localparam logic [7:0] HDR_IR_TMS = 8'h03;
  localparam logic [5:0] HDR_IR_CNT = 6'h04;
  localparam logic [7:0] HDR_DR_TMS = 8'h01;
  localparam logic [5:0] HDR_DR_CNT = 6'h03;
  localparam logic [7:0] ESC_TMS    = 8'h1F;
  localparam logic [5:0] ESC_CNT    = 6'h06;
  localparam logic [5:0] TAIL_CNT   = 6'h02;
  localparam logic [5:0] FULL_LEN   = 6'h20;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_t;

  typedef enum logic [2:0] {
    CH_ID, CH_BYPASS, CH_BOUNDARY, CH_PROG, CH_ISCAN, CH_BREAK
  } chain_t;

  typedef enum logic [1:0] {CMD_RESET, CMD_IR, CMD_DR} cmd_kind_t;
endpackage : tap_pkg

// *** src/tap_link_if.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose : the four test port wires between host and device
// Assumes : data output has a pull-up on the board
// Notes   : tdo_line resolves the released output to the pulled-up level
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  logic tdo_line;

  // released output floats high through the board pull-up
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

  modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
  modport host (output tck, output tms, output tdi, input tdo_line);
endinterface : tap_link_if

// *** src/tap_device.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose : device end of the test access port: controller, IR and data chains
// Assumes : link pins are asynchronous to core_clk and sampled by it
// Notes   : link clock must stay well below a quarter of core_clk
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module tap_device
  import tap_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h0000_1001  // arbitrary identification value
)(
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               test_port_enable_fuse,
  input  wire logic               test_port_disable_bit,
  input  wire logic [BND_W-1:0]   bnd_in,
  input  wire logic [AUX_W-1:0]   aux_in,
  output logic      [IR_W-1:0]    instr,
  output chain_t                  chain_sel,
  output logic      [BND_W-1:0]   bnd_out,
  output logic      [AUX_W-1:0]   aux_out,
  output logic                    run_idle,
  output logic                    port_gpio,
  output logic                    pullup_en,
  tap_link_if.dev                 link
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: bit 0 clock, bit 1 mode select, bit 2 data in
  logic [2:0] s1_q, s2_q, s3_q, f_q;
  logic [2:0] f_d;
  logic       tck_rise, tck_fall, tms, tdi;

  // a level counts only once the second and third stages agree
  genvar g;
  for (g = 0; g < 3; g++)
  begin : g_filt
    assign f_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : f_q[g];
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
      f_q  <= 3'h7;
    end
    else
    begin
      s1_q <= {link.tdi, link.tms, link.tck};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  assign tck_rise = f_d[0] & ~f_q[0];
  assign tck_fall = ~f_d[0] & f_q[0];
  assign tms      = f_q[1];
  assign tdi      = f_q[2];

  //////////////////////////////////////////////////////////////////////////////
  // controller transitions on mode select
  function automatic tap_state_t next_state(input tap_state_t s, input logic m);
    unique case (s)
      ST_TLR:    next_state = m ? ST_TLR    : ST_RTI;
      ST_RTI:    next_state = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = m ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  next_state = m ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = m ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = m ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  next_state = m ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = m ? ST_SEL_DR : ST_RTI;
    endcase
  endfunction : next_state

  // instruction to chain; 5-7, 9 and B alias PROG, ISCAN and BREAK; only 3 and C-F fall back to the one-bit bypass
  function automatic chain_t decode_chain(input logic [IR_W-1:0] ir);
    if (ir == INSTR_ID)
      decode_chain = CH_ID;
    else if (ir == INSTR_BND_DRIVE || ir == INSTR_BND_SAMPLE)
      decode_chain = CH_BOUNDARY;
    else if (ir[3:2] == INSTR_PROG[3:2])
      decode_chain = CH_PROG;
    else if (ir[3:1] == INSTR_ISCAN[3:1])
      decode_chain = CH_ISCAN;
    else if (ir[3:1] == INSTR_BREAK[3:1])
      decode_chain = CH_BREAK;
    else
      decode_chain = CH_BYPASS;
  endfunction : decode_chain

  // chain length sets where the incoming bit enters the shared shifter
  function automatic logic [DR_W-1:0] dr_shift(input logic [DR_W-1:0] sr,
                                               input logic d, input chain_t c);
    dr_shift = {d, sr[DR_W-1:1]};
    if (c == CH_BYPASS)
      dr_shift = {{(DR_W-1){1'b0}}, d};
    else if (c != CH_ID)
      dr_shift = {{(DR_W-BND_W){1'b0}}, d, sr[BND_W-1:1]};
  endfunction : dr_shift

  //////////////////////////////////////////////////////////////////////////////
  // controller, shifters and latches
  tap_state_t       st_q, st_d;
  chain_t           chain_q, chain_d;
  logic [IR_W-1:0]  ir_sr_q, ir_sr_d, ir_q, ir_d;
  logic [DR_W-1:0]  dr_sr_q, dr_sr_d;
  logic [BND_W-1:0] bnd_q, bnd_d;
  logic [AUX_W-1:0] aux_q, aux_d;
  logic             tdo_q, tdo_d, oe_n_q, oe_n_d;
  logic             idle_q, idle_d, gpio_q, gpio_d, pull_q, pull_d, en;

  assign en = test_port_enable_fuse & ~test_port_disable_bit;

  always_comb
  begin
    st_d    = st_q;
    chain_d = chain_q;
    ir_sr_d = ir_sr_q;
    ir_d    = ir_q;
    dr_sr_d = dr_sr_q;
    bnd_d   = bnd_q;
    aux_d   = aux_q;
    tdo_d   = tdo_q;
    oe_n_d  = oe_n_q;
    gpio_d  = ~test_port_enable_fuse;
    pull_d  = en;
    idle_d  = en && (st_q == ST_RTI);
    if (!en)
    begin
      st_d    = ST_TLR;
      ir_d    = INSTR_ID;
      chain_d = CH_ID;
      oe_n_d  = 1'b1;
    end
    else if (tck_rise)
    begin
      st_d = next_state(st_q, tms);
      // exit and pause states fall to the default and leave data alone
      case (st_q)
        ST_TLR:
        begin
          ir_d    = INSTR_ID;
          chain_d = CH_ID;
        end
        ST_CAP_IR: ir_sr_d = IR_CAPTURE;
        ST_SH_IR:  ir_sr_d = {tdi, ir_sr_q[IR_W-1:1]};
        ST_UPD_IR:
        begin
          ir_d    = ir_sr_q;
          chain_d = decode_chain(ir_sr_q);
        end
        ST_CAP_DR:
        begin
          unique case (chain_q)
            CH_ID:       dr_sr_d = ID_CODE;
            CH_BYPASS:   dr_sr_d = '0;
            CH_BOUNDARY: dr_sr_d = {{(DR_W-BND_W){1'b0}}, bnd_in};
            default:     dr_sr_d = {{(DR_W-AUX_W){1'b0}}, aux_in};
          endcase
        end
        ST_SH_DR:  dr_sr_d = dr_shift(dr_sr_q, tdi, chain_q);
        ST_UPD_DR:
        begin
          if (chain_q == CH_BOUNDARY)
            bnd_d = dr_sr_q[BND_W-1:0];
          else if (chain_q != CH_ID && chain_q != CH_BYPASS)
            aux_d = dr_sr_q[AUX_W-1:0];
        end
        default: ;
      endcase
    end
    else if (tck_fall)
    begin
      // driving only on the falling edge gives the host a full half period
      oe_n_d = 1'b1;
      if (st_q == ST_SH_IR)
      begin
        tdo_d  = ir_sr_q[0];
        oe_n_d = 1'b0;
      end
      else if (st_q == ST_SH_DR)
      begin
        tdo_d  = dr_sr_q[0];
        oe_n_d = 1'b0;
      end
    end
  end

  // only the reset input reaches here; there is no test reset pin
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_q    <= ST_TLR;
      chain_q <= CH_ID;
      ir_sr_q <= IR_CAPTURE;
      ir_q    <= INSTR_ID;
      dr_sr_q <= '0;
      bnd_q   <= '0;
      aux_q   <= '0;
      tdo_q   <= 1'b1;
      oe_n_q  <= 1'b1;
      idle_q  <= 1'b0;
      gpio_q  <= 1'b1;
      pull_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      chain_q <= chain_d;
      ir_sr_q <= ir_sr_d;
      ir_q    <= ir_d;
      dr_sr_q <= dr_sr_d;
      bnd_q   <= bnd_d;
      aux_q   <= aux_d;
      tdo_q   <= tdo_d;
      oe_n_q  <= oe_n_d;
      idle_q  <= idle_d;
      gpio_q  <= gpio_d;
      pull_q  <= pull_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign link.tdo      = tdo_q;
  assign link.tdo_oe_n = oe_n_q;
  assign instr         = ir_q;
  assign chain_sel     = chain_q;
  assign bnd_out       = bnd_q;
  assign aux_out       = aux_q;
  assign run_idle      = idle_q;
  assign port_gpio     = gpio_q;
  assign pullup_en     = pull_q;

endmodule : tap_device

// *** src/tap_host.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose : host end: runs reset, instruction and data scans over the port
// Assumes : the device starts in Run-Test/Idle, as after an escape
// Notes   : link clock is core_clk divided; it stops low between scans
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module tap_host
  import tap_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             cmd_valid,
  input  cmd_kind_t             cmd_kind,
  input  wire logic [5:0]       cmd_len,
  input  wire logic [DR_W-1:0]  cmd_data,
  output logic                  cmd_ready,
  output logic                  resp_valid,
  output logic      [DR_W-1:0]  resp_data,
  tap_link_if.host              link
);

  //////////////////////////////////////////////////////////////////////////////
  // data output synchroniser, counted once stages two and three agree
  logic s1_q, s2_q, s3_q, tdo_q, tdo_d;

  assign tdo_d = (s2_q == s3_q) ? s3_q : tdo_q;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      s3_q  <= 1'b1;
      tdo_q <= 1'b1;
    end
    else
    begin
      s1_q  <= link.tdo_line;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      tdo_q <= tdo_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan sequencer: mode select and data vectors are sent one bit per period
  typedef enum logic {H_IDLE, H_RUN} host_state_t;

  host_state_t      st_q, st_d;
  logic [4:0]       div_q, div_d;
  logic [5:0]       bit_q, bit_d, tot_q, tot_d, lo_q, lo_d, len_q, len_d;
  logic [VEC_W-1:0] tmsv_q, tmsv_d, tdiv_q, tdiv_d;
  logic [DR_W-1:0]  rx_q, rx_d, resp_q, resp_d;
  logic             tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d;
  logic             rdy_q, rdy_d, rv_q, rv_d;
  logic [7:0]       hdr;
  logic [5:0]       hcnt;

  always_comb
  begin
    st_d   = st_q;
    div_d  = div_q;
    bit_d  = bit_q;
    tot_d  = tot_q;
    lo_d   = lo_q;
    len_d  = len_q;
    tmsv_d = tmsv_q;
    tdiv_d = tdiv_q;
    rx_d   = rx_q;
    resp_d = resp_q;
    tck_d  = tck_q;
    tms_d  = tms_q;
    tdi_d  = tdi_q;
    rdy_d  = rdy_q;
    rv_d   = 1'b0;
    hdr    = ESC_TMS;
    hcnt   = ESC_CNT;
    unique case (st_q)
      H_IDLE:
      begin
        if (cmd_valid && rdy_q)
        begin
          // escape is five ones then a zero into Run-Test/Idle
          if (cmd_kind == CMD_IR)
          begin
            hdr  = HDR_IR_TMS;
            hcnt = HDR_IR_CNT;
          end
          else if (cmd_kind == CMD_DR)
          begin
            hdr  = HDR_DR_TMS;
            hcnt = HDR_DR_CNT;
          end
          len_d  = (cmd_kind == CMD_RESET) ? 6'h00 : cmd_len;
          tmsv_d = {{(VEC_W-8){1'b0}}, hdr};
          // last data bit raises mode select, then update, then idle
          if (cmd_kind != CMD_RESET)
            tmsv_d = tmsv_d | (VEC_W'(3) << (hcnt + cmd_len - 6'h01));
          tdiv_d = VEC_W'(cmd_data) << hcnt;
          tot_d  = (cmd_kind == CMD_RESET) ? hcnt : hcnt + cmd_len + TAIL_CNT;
          lo_d   = hcnt;
          bit_d  = 6'h00;
          div_d  = 5'h00;
          tms_d  = tmsv_d[0];
          tdi_d  = tdiv_d[0];
          rx_d   = '0;
          rdy_d  = 1'b0;
          st_d   = H_RUN;
        end
      end
      H_RUN:
      begin
        div_d = div_q + 5'h01;
        if (div_q == TCK_HALF_LAST)
        begin
          div_d = 5'h00;
          tck_d = ~tck_q;
          if (!tck_q)
          begin
            // rising edge: the device shifts; catch its bit just before
            if (bit_q >= lo_q && bit_q < lo_q + len_q)
              rx_d = {tdo_q, rx_q[DR_W-1:1]};
          end
          else if (bit_q + 6'h01 == tot_q)
          begin
            // falling edge after the last bit: stop the clock, report
            st_d   = H_IDLE;
            rdy_d  = 1'b1;
            rv_d   = 1'b1;
            resp_d = rx_q >> (FULL_LEN - len_q);
          end
          else
          begin
            bit_d = bit_q + 6'h01;
            tms_d = tmsv_q[bit_d];
            tdi_d = tdiv_q[bit_d];
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_q   <= H_IDLE;
      div_q  <= 5'h00;
      bit_q  <= 6'h00;
      tot_q  <= 6'h00;
      lo_q   <= 6'h00;
      len_q  <= 6'h00;
      tmsv_q <= '0;
      tdiv_q <= '0;
      rx_q   <= '0;
      resp_q <= '0;
      tck_q  <= 1'b0;
      tms_q  <= 1'b1;
      tdi_q  <= 1'b1;
      rdy_q  <= 1'b1;
      rv_q   <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      div_q  <= div_d;
      bit_q  <= bit_d;
      tot_q  <= tot_d;
      lo_q   <= lo_d;
      len_q  <= len_d;
      tmsv_q <= tmsv_d;
      tdiv_q <= tdiv_d;
      rx_q   <= rx_d;
      resp_q <= resp_d;
      tck_q  <= tck_d;
      tms_q  <= tms_d;
      tdi_q  <= tdi_d;
      rdy_q  <= rdy_d;
      rv_q   <= rv_d;
    end
  end

  assign link.tck   = tck_q;
  assign link.tms   = tms_q;
  assign link.tdi   = tdi_q;
  assign cmd_ready  = rdy_q;
  assign resp_valid = rv_q;
  assign resp_data  = resp_q;

endmodule : tap_host

// *** tb/tap_link_chk.sv ***
// Purpose : wire-level checks on the link between host and device
// Assumes : the host makes the link clock as core_clk divided by twenty
// Notes   : ones_q counts consecutive link rises with mode select high
`timescale 1ns/1ps
module tap_link_chk
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic tdo_line
);
  logic       tck_q;
  logic [2:0] ones_q;
  logic [2:0] ones_d;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // saturating count of rises with mode select high
  always_comb
  begin
    ones_d = ones_q;
    if (tck && !tck_q)
      ones_d = !tms ? 3'h0 : (ones_q == 3'h5) ? 3'h5 : ones_q + 3'h1;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tck_q  <= 1'b0;
      ones_q <= 3'h0;
    end
    else
    begin
      tck_q  <= tck;
      ones_q <= ones_d;
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs move only in the low phase, so the far end samples settled data
  tdo_edge_a : assert property ($changed(tdo) |-> !tck)
    else $error("data out moved in high phase");
  oe_edge_a : assert property ($changed(tdo_oe_n) |-> !tck)
    else $error("enable moved in high phase");
  // host holds its lines over each high phase
  tms_hold_a : assert property (tck && $past(tck) |-> $stable(tms))
    else $error("mode select moved in high phase");
  tdi_hold_a : assert property (tck && $past(tck) |-> $stable(tdi))
    else $error("data in moved in high phase");
  clk_high_a : assert property ($rose(tck) |-> tck[*8] ##1 tck ##1 tck ##1 !tck)
    else $error("link high phase not ten cycles");
  clk_low_a : assert property ($fell(tck) |-> (!tck)[*8] ##1 !tck ##1 !tck)
    else $error("link low phase too short");
  // two high mode selects leave any shift state, so the output must float
  escape_float_a : assert property (ones_q >= 3'h2 |-> tdo_oe_n)
    else $error("output driven after escape");
  shift_end_a : assert property ($fell(tdo_oe_n) |-> ##[1:800] $rose(tdo_oe_n))
    else $error("output driven too long");

  cover property ($fell(tdo_oe_n));
  cover property (ones_q == 3'h5);
  cover property (tdo_oe_n && tdo_line);
endmodule : tap_link_chk

// *** tb/test_jtag_tap_controller.sv ***
// Purpose : drives scans through both ends and checks results
// Assumes : the host expects the device in Run-Test/Idle; an escape gets it there
// Notes   : fuse and disable inputs change only between scans
`timescale 1ns/1ps
module test_jtag_tap_controller
  import tap_pkg::*;
;
  localparam logic [31:0] ID_VAL = 32'h0000_3A5B;  // arbitrary identification value
  localparam int          N_ENT  = 7;

  logic             core_clk;
  logic             reset;
  logic             test_port_enable_fuse;
  logic             test_port_disable_bit;
  logic [BND_W-1:0] bnd_in;
  logic [AUX_W-1:0] aux_in;
  logic [IR_W-1:0]  instr;
  chain_t           chain_sel;
  logic [BND_W-1:0] bnd_out;
  logic [AUX_W-1:0] aux_out;
  logic             run_idle;
  logic             port_gpio;
  logic             pullup_en;
  logic             cmd_valid;
  cmd_kind_t        cmd_kind;
  logic [5:0]       cmd_len;
  logic [DR_W-1:0]  cmd_data;
  logic             cmd_ready;
  logic             resp_valid;
  logic [DR_W-1:0]  resp_data;
  logic [DR_W-1:0]  resp;
  logic [DR_W-1:0]  exp_val;
  logic [DR_W-1:0]  data;
  logic [7:0]       bnd_exp;
  logic [7:0]       aux_exp;
  int               fail_count;
  int               checked;
  // each instruction and the chain it must select
  logic [3:0]       codes [N_ENT] = '{INSTR_BND_DRIVE, INSTR_ID, INSTR_BND_SAMPLE,
                                      INSTR_PROG, INSTR_ISCAN, INSTR_BREAK, INSTR_BYPASS};
  chain_t           chains [N_ENT] = '{CH_BOUNDARY, CH_ID, CH_BOUNDARY, CH_PROG,
                                       CH_ISCAN, CH_BREAK, CH_BYPASS};

  tap_link_if tap_link_if_inst ();

  tap_host tap_host_inst (
    .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .link(tap_link_if_inst));

  tap_device #(.ID_CODE(ID_VAL)) tap_device_inst (
    .core_clk(core_clk), .reset(reset), .test_port_enable_fuse(test_port_enable_fuse),
    .test_port_disable_bit(test_port_disable_bit), .bnd_in(bnd_in), .aux_in(aux_in),
    .instr(instr), .chain_sel(chain_sel), .bnd_out(bnd_out), .aux_out(aux_out),
    .run_idle(run_idle), .port_gpio(port_gpio), .pullup_en(pullup_en),
    .link(tap_link_if_inst));

  tap_link_chk tap_link_chk_inst (
    .core_clk(core_clk), .reset(reset), .tck(tap_link_if_inst.tck),
    .tms(tap_link_if_inst.tms), .tdi(tap_link_if_inst.tdi), .tdo(tap_link_if_inst.tdo),
    .tdo_oe_n(tap_link_if_inst.tdo_oe_n), .tdo_line(tap_link_if_inst.tdo_line));

  ////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // one comparison; an unknown never matches
  task check(input string name, input logic [DR_W-1:0] seen, input logic [DR_W-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // one host command; bounded wait so a lost answer cannot hang the run
  task scan(input cmd_kind_t kind, input logic [5:0] len, input logic [DR_W-1:0] d);
    int n;
    @(negedge core_clk);
    check("cmd_ready", cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd_kind  = kind;
    cmd_len   = len;
    cmd_data  = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    check("cmd_busy", cmd_ready, 1'b0);
    n = 0;
    while (resp_valid !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    check("resp_valid", resp_valid, 1'b1);
    resp = resp_data;
  endtask : scan

  // instruction scan from idle
  task set_ir(input logic [3:0] code);
    scan(CMD_IR, 6'h04, {28'h0, code});
    check("ir_capture", resp[3:0], 4'h1);
    check("instr", instr, code);
    check("run_idle", run_idle, 1'b1);
  endtask : set_ir

  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    fail_count = 0;
    checked = 0;
    reset = 1'b1;
    test_port_enable_fuse = 1'b1;
    test_port_disable_bit = 1'b0;
    bnd_in = 8'hC3;
    aux_in = 8'h96;
    cmd_valid = 1'b0;
    cmd_kind = CMD_RESET;
    cmd_len = 6'h00;
    cmd_data = 32'h0;
    bnd_exp = 8'h00;
    aux_exp = 8'h00;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    check("instr", instr, INSTR_ID);
    check("chain_sel", chain_sel, CH_ID);
    check("run_idle", run_idle, 1'b0);
    check("pullup_en", pullup_en, 1'b1);
    check("port_gpio", port_gpio, 1'b0);
    check("tdo_line", tap_link_if_inst.tdo_line, 1'b1);
    // the host needs idle first; the escape ends there
    scan(CMD_RESET, ESC_CNT, 32'h0);
    check("run_idle", run_idle, 1'b1);
    // each instruction: its chain, the captured word, the update latches
    for (int i = 0; i < N_ENT; i++)
    begin
      data = {24'h12_3456, codes[i], ~codes[i]};
      aux_in = aux_in + 8'h11;
      set_ir(codes[i]);
      check("chain_sel", chain_sel, chains[i]);
      case (chains[i])
        CH_ID:       exp_val = ID_VAL;
        CH_BYPASS:   exp_val = {24'h0, data[6:0], 1'b0};
        CH_BOUNDARY: exp_val = {24'h0, bnd_in};
        default:     exp_val = {24'h0, aux_in};
      endcase
      scan(CMD_DR, (chains[i] == CH_ID) ? 6'h20 : 6'h08, data);
      if (chains[i] != CH_ID)
        resp = {24'h0, resp[7:0]};
      check("dr_capture", resp, exp_val);
      if (chains[i] == CH_BOUNDARY)
        bnd_exp = data[7:0];
      else if (chains[i] != CH_ID && chains[i] != CH_BYPASS)
        aux_exp = data[7:0];
      check("bnd_out", bnd_out, bnd_exp);
      check("aux_out", aux_out, aux_exp);
    end
    // five high mode selects reload the identification code
    scan(CMD_RESET, ESC_CNT, 32'h0);
    check("instr", instr, INSTR_ID);
    check("chain_sel", chain_sel, CH_ID);
    // disable bit: controller held, output never driven
    set_ir(INSTR_BYPASS);
    test_port_disable_bit = 1'b1;
    repeat (4) @(negedge core_clk);
    check("pullup_en", pullup_en, 1'b0);
    check("port_gpio", port_gpio, 1'b0);
    scan(CMD_IR, 6'h04, 32'h0000_0002);
    check("ir_float", resp[3:0], 4'hF);
    check("instr", instr, INSTR_ID);
    // fuse clear: pins are general purpose
    test_port_disable_bit = 1'b0;
    test_port_enable_fuse = 1'b0;
    repeat (4) @(negedge core_clk);
    check("port_gpio", port_gpio, 1'b1);
    check("pullup_en", pullup_en, 1'b0);
    scan(CMD_IR, 6'h04, 32'h0000_0002);
    check("ir_float", resp[3:0], 4'hF);
    check("instr", instr, INSTR_ID);
    test_port_enable_fuse = 1'b1;
    repeat (4) @(negedge core_clk);
    check("pullup_en", pullup_en, 1'b1);
    // mid-run reset clears the latches and the instruction
    // system reset raised high mid-run, as an attached debugger may do
    reset = 1'b1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    check("instr", instr, INSTR_ID);
    check("bnd_out", bnd_out, 8'h00);
    check("aux_out", aux_out, 8'h00);
    scan(CMD_RESET, ESC_CNT, 32'h0);
    set_ir(INSTR_BND_SAMPLE);
    check("chain_sel", chain_sel, CH_BOUNDARY);
    stop_test();
  end

  // the sequence needs well under a millisecond; this cuts a hang short
  initial
  begin
    #3_000_000;
    fail_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : test_jtag_tap_controller
